// ---- dds_ctrl.sv ----
// i/o line, data-ready, aux dac and self-test control behind the serial register port
`timescale 1ns/1ps
// Function
// [R01] line owner priority: data-ready, then alarm output, then general i/o control
// [R02] i/o control bits 3:0 set direction of lines four..one, 1 = output
// [R03] output lines drive the level held in i/o control bits 11:8
// [R04] reading i/o control returns sampled pin state for input lines
// [R05] write frame: top bit set, 7-bit byte address, one data byte
// [R06] read frame: top bit clear, address in upper byte; 16-bit register returned
// [R07] external sample clock on line four when it is input and period is zero
// [R08] misc control resets to 0x0006: data-ready on, active high, line one
// [R09] misc bits 2:0: data-ready enable, polarity, line select
// [R10] data-ready pulse lasts between 100 and 200 us
// [R11] misc bit 11 starts memory test, cleared when test completes
// [R12] misc bit 10 runs self-test, posts results, then clears itself
// [R13] misc bits 9 and 8 hold negative and positive stimulus while set
// [R14] misc bit 7 enables gyro bias compensation, bit 6 origin alignment
// [R15] dac holding register keeps a 12-bit code in bits 11:0
// [R16] dac output changes only on latch command, both bytes together
// [R17] host writes dac low byte, high byte, then the latch bit
// [R18] host sequences manual self-test with settle waits and clears bits afterwards
// [R19] self-test results land in diagnostic bits 15:10 and bit 5
// [R20] memory test result lands in diagnostic bit 6
// [R21] output lines read back the level currently driven
module dds_ctrl (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  input wire logic [3:0] io_line_i,
  output logic [3:0] io_line_o,
  output logic [3:0] io_line_oe_o,
  input wire logic int_sample_tick_i,
  input wire logic alarm_active_i,
  input wire logic selftest_done_i,
  input wire logic [5:0] selftest_axis_fail_i,
  input wire logic memtest_done_i,
  input wire logic memtest_fail_i,
  output logic sample_strobe_o,
  output logic [7:0] sample_period_o,
  output logic selftest_start_o,
  output logic memtest_start_o,
  output logic stim_neg_o,
  output logic stim_pos_o,
  output logic bias_comp_en_o,
  output logic origin_align_en_o,
  output logic [dds_pkg::DAC_W-1:0] dac_code_o
);

  // ----------------------------------------------------------------
  // link domain: serial frame in, response out
  // ----------------------------------------------------------------
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [15:0] rx_reg, rx_next;
  dds_pkg::dds_cmd_t cmd_word_reg, cmd_word_next;
  logic cmd_tgl_reg, cmd_tgl_next;
  logic [15:0] tx_reg, tx_next;
  logic [15:0] resp_reg, resp_next;
  logic link_clr;

  assign link_clr = rst_i | spi_cs_n_i;

  always_comb begin
    rx_next = {rx_reg[14:0], spi_mosi_i};
    bit_cnt_next = bit_cnt_reg + 4'h1;
    cmd_word_next = cmd_word_reg;
    cmd_tgl_next = cmd_tgl_reg;
    if (bit_cnt_reg == 4'hF) begin
      cmd_word_next = rx_next; // R05 R06
      cmd_tgl_next = ~cmd_tgl_reg;
    end
    // response word is loaded at the frame's first falling edge
    if (bit_cnt_reg == 4'h0) begin
      tx_next = resp_reg; // R06
    end else begin
      tx_next = {tx_reg[14:0], 1'b0};
    end
  end

  // counter restarts with every frame, so a cut-short frame is dropped
  always_ff @(posedge spi_sclk_i or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt_reg <= 4'h0;
      rx_reg <= 16'h0000;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      rx_reg <= rx_next;
    end
  end

  always_ff @(posedge spi_sclk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_word_reg <= '0;
      cmd_tgl_reg <= 1'b0;
    end else begin
      cmd_word_reg <= cmd_word_next;
      cmd_tgl_reg <= cmd_tgl_next;
    end
  end

  always_ff @(negedge spi_sclk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_reg <= 16'h0000;
    end else begin
      tx_reg <= tx_next;
    end
  end

  assign spi_miso_o = tx_reg[15];

  // ----------------------------------------------------------------
  // crossings into the system domain
  // ----------------------------------------------------------------
  logic cmd_tgl_s;
  logic [3:0] io_s;
  logic cmd_seen_reg;
  logic line4_prev_reg;
  logic new_cmd;
  logic ext_edge;

  dds_sync #(.W(1)) u_sync_cmd (
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i(cmd_tgl_reg),
    .q_o(cmd_tgl_s)
  );

  dds_sync #(.W(4)) u_sync_io (
    .clk_i(sys_clk_i),
    .rst_i(rst_i),
    .d_i(io_line_i),
    .q_o(io_s)
  );

  // the command word is held stable for a whole frame, far longer than the toggle takes to cross
  assign new_cmd = cmd_tgl_s ^ cmd_seen_reg;
  assign ext_edge = io_s[dds_pkg::EXT_CLK_LINE] & ~line4_prev_reg;

  // ----------------------------------------------------------------
  // test sequencer
  // ----------------------------------------------------------------
  dds_pkg::dds_test_t tst_reg, tst_next;
  logic st_start_reg, st_start_next;
  logic mt_start_reg, mt_start_next;
  logic bist_end;
  logic mem_end;
  logic [15:0] gpio_reg, gpio_next;
  logic [15:0] msc_reg, msc_next;

  always_comb begin
    tst_next = tst_reg;
    st_start_next = 1'b0;
    mt_start_next = 1'b0;
    bist_end = 1'b0;
    mem_end = 1'b0;
    case (tst_reg)
      dds_pkg::TST_IDLE: begin
        if (msc_reg[dds_pkg::MSC_BIST_BIT]) begin
          tst_next = dds_pkg::TST_BIST; // R12
          st_start_next = 1'b1;
        end else if (msc_reg[dds_pkg::MSC_MEM_BIT]) begin
          tst_next = dds_pkg::TST_MEM; // R11
          mt_start_next = 1'b1;
        end
      end
      dds_pkg::TST_BIST: begin
        if (selftest_done_i) begin
          bist_end = 1'b1;
          tst_next = dds_pkg::TST_IDLE;
        end
      end
      dds_pkg::TST_MEM: begin
        if (memtest_done_i) begin
          mem_end = 1'b1;
          tst_next = dds_pkg::TST_IDLE;
        end
      end
      default: tst_next = dds_pkg::TST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [15:0] dac_hold_reg, dac_hold_next;
  logic [15:0] smpl_reg, smpl_next;
  logic [15:0] alm_reg, alm_next;
  logic [dds_pkg::DAC_W-1:0] dac_out_reg, dac_out_next;
  logic [5:0] diag_axis_reg, diag_axis_next;
  logic diag_bist_reg, diag_bist_next;
  logic diag_mem_reg, diag_mem_next;
  logic [3:0] out_reg, out_next;
  logic [3:0] oe_reg, oe_next;
  logic [3:0] lvl_rd;
  logic [15:0] rd_data;
  logic [6:0] reg_addr;

  function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi, input logic [7:0] d,
                                           input logic [15:0] mask);
    logic [15:0] v;
    v = hi ? {d, old[7:0]} : {old[15:8], d};
    return v & mask;
  endfunction

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lvl_rd[i] = oe_reg[i] ? out_reg[i] : io_s[i]; // R04 R21
    end
    reg_addr = {cmd_word_reg.addr[6:1], 1'b0};
    case (reg_addr)
      dds_pkg::GPIO_ADDR: rd_data = {4'h0, lvl_rd, 4'h0, gpio_reg[3:0]};
      dds_pkg::MSC_ADDR: rd_data = msc_reg;
      dds_pkg::DAC_ADDR: rd_data = dac_hold_reg;
      dds_pkg::SMPL_ADDR: rd_data = smpl_reg;
      dds_pkg::ALM_ADDR: rd_data = alm_reg;
      dds_pkg::DIAG_ADDR: rd_data = {diag_axis_reg, 3'b000, diag_mem_reg, diag_bist_reg, 5'b00000}; // R19 R20
      default: rd_data = 16'h0000;
    endcase
  end

  always_comb begin
    gpio_next = gpio_reg;
    msc_next = msc_reg;
    dac_hold_next = dac_hold_reg;
    smpl_next = smpl_reg;
    alm_next = alm_reg;
    dac_out_next = dac_out_reg;
    resp_next = resp_reg;
    diag_axis_next = diag_axis_reg;
    diag_bist_next = diag_bist_reg;
    diag_mem_next = diag_mem_reg;
    // completion clears first so that a fresh write of 1 in the same cycle survives
    if (bist_end) begin
      msc_next[dds_pkg::MSC_BIST_BIT] = 1'b0; // R12
    end
    if (mem_end) begin
      msc_next[dds_pkg::MSC_MEM_BIT] = 1'b0; // R11
    end
    if (new_cmd) begin
      if (cmd_word_reg.wr) begin
        case (reg_addr) // R05
          dds_pkg::GPIO_ADDR: gpio_next = put_byte(gpio_reg, cmd_word_reg.addr[0], cmd_word_reg.data,
                                                   dds_pkg::GPIO_MASK); // R02 R03
          dds_pkg::MSC_ADDR: begin
            // built on msc_next so a low-byte write cannot undo a completion clear in the same cycle
            msc_next = put_byte(msc_next, cmd_word_reg.addr[0], cmd_word_reg.data, dds_pkg::MSC_MASK); // R09 R13 R14
            // trigger bits only set from the port; hardware clears them
            msc_next[dds_pkg::MSC_BIST_BIT] = msc_next[dds_pkg::MSC_BIST_BIT] |
                                               (msc_reg[dds_pkg::MSC_BIST_BIT] & ~bist_end);
            msc_next[dds_pkg::MSC_MEM_BIT] = msc_next[dds_pkg::MSC_MEM_BIT] |
                                              (msc_reg[dds_pkg::MSC_MEM_BIT] & ~mem_end);
          end
          dds_pkg::DAC_ADDR: dac_hold_next = put_byte(dac_hold_reg, cmd_word_reg.addr[0], cmd_word_reg.data,
                                                      dds_pkg::DAC_MASK); // R15 R16
          dds_pkg::SMPL_ADDR: smpl_next = put_byte(smpl_reg, cmd_word_reg.addr[0], cmd_word_reg.data,
                                                   dds_pkg::SMPL_MASK);
          dds_pkg::ALM_ADDR: alm_next = put_byte(alm_reg, cmd_word_reg.addr[0], cmd_word_reg.data,
                                                 dds_pkg::ALM_MASK);
          dds_pkg::GLOB_ADDR: begin
            if (!cmd_word_reg.addr[0] && cmd_word_reg.data[dds_pkg::GLOB_LATCH_BIT]) begin
              dac_out_next = dac_hold_reg[dds_pkg::DAC_W-1:0]; // R16 R17
            end
          end
          default: ;
        endcase
      end else begin
        resp_next = rd_data; // R06
        if (reg_addr == dds_pkg::DIAG_ADDR) begin
          diag_axis_next = 6'h00;
          diag_bist_next = 1'b0;
          diag_mem_next = 1'b0;
        end
      end
    end
    // results set after the read-clear, so a result arriving with the read is kept
    if (bist_end) begin
      diag_axis_next = diag_axis_next | selftest_axis_fail_i; // R19
      diag_bist_next = diag_bist_next | (|selftest_axis_fail_i); // R12 R19
    end
    if (mem_end) begin
      diag_mem_next = diag_mem_next | memtest_fail_i; // R20
    end
  end

  // ----------------------------------------------------------------
  // sample strobe, data-ready pulse and line drivers
  // ----------------------------------------------------------------
  logic ext_mode;
  logic strobe_reg, strobe_next;
  logic [dds_pkg::DRDY_W-1:0] drdy_cnt_reg, drdy_cnt_next;
  logic drdy_act;
  logic alm_lvl;
  logic drdy_lvl;

  assign ext_mode = ~gpio_reg[dds_pkg::GPIO_DIR_LSB + dds_pkg::EXT_CLK_LINE] & (smpl_reg[7:0] == 8'h00);
  assign drdy_act = (drdy_cnt_reg != '0);

  always_comb begin
    strobe_next = ext_mode ? ext_edge : int_sample_tick_i; // R07
    drdy_cnt_next = drdy_cnt_reg;
    // a sample during a running pulse does not stretch it, so the width stays fixed
    if (strobe_reg && !drdy_act) begin
      drdy_cnt_next = dds_pkg::DRDY_W'(dds_pkg::DRDY_CYCLES); // R10
    end else if (drdy_act) begin
      drdy_cnt_next = drdy_cnt_reg - 1'b1;
    end
    alm_lvl = alm_reg[dds_pkg::OUT_POL_BIT] ? alarm_active_i : ~alarm_active_i;
    drdy_lvl = msc_reg[dds_pkg::OUT_POL_BIT] ? drdy_act : ~drdy_act; // R09
    for (int i = 0; i < 4; i++) begin
      oe_next[i] = gpio_reg[dds_pkg::GPIO_DIR_LSB + i]; // R02
      out_next[i] = gpio_reg[dds_pkg::GPIO_LVL_LSB + i]; // R03
      if (i < 2 && alm_reg[dds_pkg::OUT_EN_BIT] && (alm_reg[dds_pkg::OUT_SEL_BIT] == i[0])) begin
        oe_next[i] = 1'b1; // R01
        out_next[i] = alm_lvl;
      end
      if (i < 2 && msc_reg[dds_pkg::OUT_EN_BIT] && (msc_reg[dds_pkg::OUT_SEL_BIT] == i[0])) begin
        oe_next[i] = 1'b1; // R01 R09
        out_next[i] = drdy_lvl;
      end
    end
  end

  // ----------------------------------------------------------------
  // system domain registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_seen_reg <= 1'b0;
      line4_prev_reg <= 1'b0;
      tst_reg <= dds_pkg::TST_IDLE;
      st_start_reg <= 1'b0;
      mt_start_reg <= 1'b0;
      gpio_reg <= dds_pkg::GPIO_RST;
      msc_reg <= dds_pkg::MSC_RST; // R08
      dac_hold_reg <= dds_pkg::DAC_RST;
      smpl_reg <= dds_pkg::SMPL_RST;
      alm_reg <= dds_pkg::ALM_RST;
      dac_out_reg <= '0;
      resp_reg <= 16'h0000;
      diag_axis_reg <= 6'h00;
      diag_bist_reg <= 1'b0;
      diag_mem_reg <= 1'b0;
      strobe_reg <= 1'b0;
      drdy_cnt_reg <= '0;
      out_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else begin
      cmd_seen_reg <= cmd_tgl_s;
      line4_prev_reg <= io_s[dds_pkg::EXT_CLK_LINE];
      tst_reg <= tst_next;
      st_start_reg <= st_start_next;
      mt_start_reg <= mt_start_next;
      gpio_reg <= gpio_next;
      msc_reg <= msc_next;
      dac_hold_reg <= dac_hold_next;
      smpl_reg <= smpl_next;
      alm_reg <= alm_next;
      dac_out_reg <= dac_out_next;
      resp_reg <= resp_next;
      diag_axis_reg <= diag_axis_next;
      diag_bist_reg <= diag_bist_next;
      diag_mem_reg <= diag_mem_next;
      strobe_reg <= strobe_next;
      drdy_cnt_reg <= drdy_cnt_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end

  assign io_line_o = out_reg;
  assign io_line_oe_o = oe_reg;
  assign sample_strobe_o = strobe_reg;
  assign sample_period_o = smpl_reg[7:0];
  assign selftest_start_o = st_start_reg;
  assign memtest_start_o = mt_start_reg;
  assign stim_neg_o = msc_reg[dds_pkg::MSC_STNEG_BIT]; // R13
  assign stim_pos_o = msc_reg[dds_pkg::MSC_STPOS_BIT]; // R13
  assign bias_comp_en_o = msc_reg[dds_pkg::MSC_BIAS_BIT]; // R14
  assign origin_align_en_o = msc_reg[dds_pkg::MSC_ORIGIN_BIT]; // R14
  assign dac_code_o = dac_out_reg;

endmodule

// ---- dds_pkg.sv ----
// constants, field layout and carrier types of the i/o line, dac and self-test control block
package dds_pkg;

  // ----------------------------------------------------------------
  // byte addresses on the serial port (low byte of each register)
  // ----------------------------------------------------------------
  localparam logic [6:0] ALM_ADDR = 7'h2E;
  localparam logic [6:0] DAC_ADDR = 7'h30;
  localparam logic [6:0] GPIO_ADDR = 7'h32;
  localparam logic [6:0] MSC_ADDR = 7'h34;
  localparam logic [6:0] SMPL_ADDR = 7'h36;
  localparam logic [6:0] DIAG_ADDR = 7'h3C;
  localparam logic [6:0] GLOB_ADDR = 7'h3E;

  // ----------------------------------------------------------------
  // reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [15:0] GPIO_RST = 16'h0000;
  localparam logic [15:0] MSC_RST = 16'h0006;
  localparam logic [15:0] DAC_RST = 16'h0000;
  localparam logic [15:0] SMPL_RST = 16'h0001;
  localparam logic [15:0] ALM_RST = 16'h0000;
  localparam logic [15:0] GPIO_MASK = 16'h0F0F;
  localparam logic [15:0] MSC_MASK = 16'h0FC7;
  localparam logic [15:0] DAC_MASK = 16'h0FFF;
  localparam logic [15:0] SMPL_MASK = 16'h00FF;
  localparam logic [15:0] ALM_MASK = 16'hFFD7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GPIO_DIR_LSB = 0;
  localparam int GPIO_LVL_LSB = 8;
  localparam int OUT_SEL_BIT = 0;
  localparam int OUT_POL_BIT = 1;
  localparam int OUT_EN_BIT = 2;
  localparam int MSC_ORIGIN_BIT = 6;
  localparam int MSC_BIAS_BIT = 7;
  localparam int MSC_STPOS_BIT = 8;
  localparam int MSC_STNEG_BIT = 9;
  localparam int MSC_BIST_BIT = 10;
  localparam int MSC_MEM_BIT = 11;
  localparam int GLOB_LATCH_BIT = 2;
  localparam int DIAG_AXIS_LSB = 10;
  localparam int DIAG_MEM_BIT = 6;
  localparam int DIAG_BIST_BIT = 5;
  localparam int EXT_CLK_LINE = 3;
  localparam int DAC_W = 12;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 25;
  localparam int DRDY_MIN_US = 100;
  localparam int DRDY_MAX_US = 200;
  localparam int DRDY_CYCLES = DRDY_MIN_US * SYS_CLK_MHZ;
  localparam int DRDY_W = $clog2(DRDY_CYCLES + 1);
  localparam int FRAME_BITS = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } dds_cmd_t;

  typedef enum logic [1:0] {
    TST_IDLE = 2'b00,
    TST_BIST = 2'b01,
    TST_MEM = 2'b11
  } dds_test_t;

endpackage

// ---- dds_sync.sv ----
// two-flop synchroniser for signals entering the system clock domain
`timescale 1ns/1ps
module dds_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d_i;
    q_next = meta_reg;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;

endmodule

// ---- dds_host_model.sv ----
// serial host model that frames commands to the control block
`timescale 1ns/1ps
module dds_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // ----------------------------------------------------------------
  // one 16-bit frame, msb first, clock idles high
  // ----------------------------------------------------------------
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    int i;
    #7 cs_n_o = 1'b0;
    for (i = 15; i >= 0; i--) begin
      #15 sclk_o = 1'b0;
      mosi_o = tx[i];
      #15 sclk_o = 1'b1;
      rx[i] = miso_i;
    end
    #15 cs_n_o = 1'b1;
    // a released line must not look like it still holds the last bit
    mosi_o = ~mosi_o;
    // gap long enough for the answer to be ready for the next frame
    #300;
  endtask
  // ----------------------------------------------------------------
  // frame cut after four bits; the block must drop it
  // ----------------------------------------------------------------
  task automatic cut(input logic [15:0] tx);
    int i;
    #7 cs_n_o = 1'b0;
    for (i = 15; i >= 12; i--) begin
      #15 sclk_o = 1'b0;
      mosi_o = tx[i];
      #15 sclk_o = 1'b1;
    end
    #15 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #300;
  endtask
endmodule

// ---- dds_ctrl_assertions.sv ----
// concurrent checks on the control block's ports
`timescale 1ns/1ps
module dds_ctrl_assertions (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic int_sample_tick_i,
  input wire logic [3:0] io_line_o,
  input wire logic [3:0] io_line_oe_o,
  input wire logic sample_strobe_o,
  input wire logic [7:0] sample_period_o,
  input wire logic selftest_start_o,
  input wire logic memtest_start_o
);
  localparam int DRDY_LO = 100 * 25;
  localparam int DRDY_HI = 200 * 25;
  logic [15:0] hi_reg;
  logic [15:0] hi_next;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // run length of line one driven high, saturating
  // ----------------------------------------------------------------
  always_comb begin
    hi_next = 16'h0000;
    if (io_line_o[0] && io_line_oe_o[0]) begin
      hi_next = (hi_reg == 16'hFFFF) ? hi_reg : hi_reg + 16'h0001;
    end
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hi_reg <= 16'h0000;
    end else begin
      hi_reg <= hi_next;
    end
  end
  sequence s_drdy_on;
    ##[1:3] io_line_o[0] [*8];
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_RST_LINE1: assert property ($past(rst_i) |-> ##1 (io_line_oe_o[0] && !io_line_o[0]))
    else $error("line one not idle data-ready after reset");
  AST_TICK_STROBE: assert property (int_sample_tick_i && sample_period_o != 8'h00 |=> sample_strobe_o)
    else $error("internal tick gave no sample strobe");
  AST_STROBE_1CYC: assert property (sample_strobe_o |=> !sample_strobe_o)
    else $error("sample strobe longer than one cycle");
  AST_DRDY_START: assert property (sample_strobe_o && io_line_oe_o[0] && !io_line_o[0] |-> s_drdy_on)
    else $error("data-ready pulse did not start");
  AST_DRDY_MIN: assert property ($fell(io_line_o[0]) && io_line_oe_o[0] |-> hi_reg >= DRDY_LO)
    else $error("data-ready pulse too short");
  AST_DRDY_MAX: assert property (hi_reg <= DRDY_HI)
    else $error("data-ready pulse too long");
  AST_ST_PULSE: assert property (selftest_start_o |=> !selftest_start_o [*8])
    else $error("self-test start retriggered");
  AST_MEM_PULSE: assert property (memtest_start_o |=> !memtest_start_o [*8])
    else $error("memory test start retriggered");
endmodule
bind dds_ctrl dds_ctrl_assertions u_chk (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .int_sample_tick_i(int_sample_tick_i),
  .io_line_o(io_line_o),
  .io_line_oe_o(io_line_oe_o),
  .sample_strobe_o(sample_strobe_o),
  .sample_period_o(sample_period_o),
  .selftest_start_o(selftest_start_o),
  .memtest_start_o(memtest_start_o)
);

// ---- dds_ctrl_tb.sv ----
// self-checking bench for the i/o line, dac and self-test control block
`timescale 1ns/1ps
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module dds_ctrl_tb;
  typedef struct {logic [6:0] a; logic [15:0] w; logic [15:0] r; logic [3:0] oe; logic [3:0] o;} dds_row_t;
  dds_row_t rows[8] = '{
    '{dds_pkg::GPIO_ADDR, 16'h080C, 16'h0A0C, 4'hD, 4'h8},
    '{dds_pkg::GPIO_ADDR, 16'hFFFF, 16'h0E0F, 4'hF, 4'hE},
    '{dds_pkg::DAC_ADDR, 16'hFFFF, 16'h0FFF, 4'hF, 4'hE},
    '{dds_pkg::ALM_ADDR, 16'hFFFF, 16'hFFD7, 4'hF, 4'hC},
    '{dds_pkg::ALM_ADDR, 16'h0000, 16'h0000, 4'hF, 4'hE},
    '{7'h10, 16'hABCD, 16'h0000, 4'hF, 4'hE},
    '{dds_pkg::SMPL_ADDR, 16'h0012, 16'h0012, 4'hF, 4'hE},
    '{dds_pkg::GLOB_ADDR, 16'h0000, 16'h0000, 4'hF, 4'hE}};
  logic sys_clk_i, rst_i, sclk, cs_n, mosi, miso, tick, alm, st_done, mt_done, mt_fail;
  logic strobe, st_start, mt_start, neg, pos, bias, orig;
  logic [5:0] st_fail;
  logic [3:0] pin_drv, io_o, io_oe;
  logic [7:0] period;
  logic [11:0] dac;
  logic [15:0] v;
  wire logic [3:0] io_in = (io_oe & io_o) | (~io_oe & pin_drv);
  int err_total = 0, check_count = 0, n_st = 0, n_mt = 0, n_sb = 0, run = 0, last_run = 0;
  dds_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
  dds_ctrl dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .io_line_i(io_in), .io_line_o(io_o), .io_line_oe_o(io_oe),
    .int_sample_tick_i(tick), .alarm_active_i(alm), .selftest_done_i(st_done),
    .selftest_axis_fail_i(st_fail), .memtest_done_i(mt_done), .memtest_fail_i(mt_fail),
    .sample_strobe_o(strobe), .sample_period_o(period), .selftest_start_o(st_start),
    .memtest_start_o(mt_start), .stim_neg_o(neg), .stim_pos_o(pos), .bias_comp_en_o(bias),
    .origin_align_en_o(orig), .dac_code_o(dac));
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // ----------------------------------------------------------------
  // event counters and line one high-run measure
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (st_start === 1'b1) n_st++;
    if (mt_start === 1'b1) n_mt++;
    if (strobe === 1'b1) n_sb++;
    if (io_o[0] === 1'b1 && io_oe[0] === 1'b1) run++;
    else if (run != 0) begin
      last_run = run;
      run = 0;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic wf(input logic [15:0] w);
    logic [15:0] d;
    host.xfer(w, d);
  endtask
  task automatic wr16(input logic [6:0] a, input logic [15:0] d);
    wf({1'b1, a[6:1], 1'b1, d[15:8]});
    wf({1'b1, a, d[7:0]});
  endtask
  // the answer to a read rides out on the following frame
  task automatic rd16(input logic [6:0] a, output logic [15:0] d);
    wf({1'b0, a, 8'h00});
    host.xfer(16'h0000, d);
  endtask
  task automatic tk;
    @(posedge sys_clk_i) tick <= 1'b1;
    @(posedge sys_clk_i) tick <= 1'b0;
  endtask
  task automatic close_out;
    if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #3000000;
    err_total++;
    close_out();
  end
  initial begin
    {rst_i, tick, alm, st_done, mt_done, mt_fail, st_fail, pin_drv} = {1'b1, 11'h000, 4'h2};
    cyc(5);
    `CHK("oe in reset", 4'h0, io_oe)
    `CHK("period in reset", 8'h01, period)
    cyc(5);
    rst_i <= 1'b0;
    cyc(2);
    rd16(dds_pkg::GPIO_ADDR, v);
    `CHK("io reset", 16'h0200, v)
    rd16(dds_pkg::MSC_ADDR, v);
    `CHK("misc reset", 16'h0006, v)
    foreach (rows[i]) begin
      wr16(rows[i].a, rows[i].w);
      rd16(rows[i].a, v);
      `CHK("reg", rows[i].r, v)
      `CHK("oe", rows[i].oe, io_oe)
      `CHK("out", rows[i].o, io_o)
      `CHK("dac hold", 12'h000, dac)
    end
    `CHK("period", 8'h12, period)
    wf(16'hB0D9);
    wf(16'hB104);
    cyc(8);
    `CHK("dac before latch", 12'h000, dac)
    wf(16'hBE04);
    `CHK("dac latched", 12'h4D9, dac)
    wr16(dds_pkg::MSC_ADDR, 16'h03C6);
    `CHK("stim bias", 4'hF, {neg, pos, bias, orig})
    wf(16'hB500);
    `CHK("stim off", 4'h3, {neg, pos, bias, orig})
    wf(16'hB504);
    rd16(dds_pkg::MSC_ADDR, v);
    `CHK("bist running", 17'h104C6, {n_st[0], v})
    @(posedge sys_clk_i) {st_done, st_fail} <= 7'h6A;
    @(posedge sys_clk_i) st_done <= 1'b0;
    rd16(dds_pkg::MSC_ADDR, v);
    `CHK("bist cleared", 16'h00C6, v)
    rd16(dds_pkg::DIAG_ADDR, v);
    `CHK("bist flags", 16'hA820, v)
    rd16(dds_pkg::DIAG_ADDR, v);
    `CHK("flags cleared", 16'h0000, v)
    wf(16'hB508);
    `CHK("mem start", 1, n_mt)
    @(posedge sys_clk_i) {mt_done, mt_fail} <= 2'h3;
    @(posedge sys_clk_i) mt_done <= 1'b0;
    rd16(dds_pkg::MSC_ADDR, v);
    `CHK("mem cleared", 16'h00C6, v)
    rd16(dds_pkg::DIAG_ADDR, v);
    `CHK("mem flag", 16'h0040, v)
    tk();
    cyc(2600);
    `CHK("drdy width", 100 * 25, last_run)
    wr16(dds_pkg::GPIO_ADDR, 16'h0000);
    wr16(dds_pkg::MSC_ADDR, 16'h00C5);
    tk();
    cyc(4);
    `CHK("drdy low line two", 3'h4, {io_oe[1], io_o[1], io_oe[0]})
    cyc(2600);
    `CHK("drdy idle line two", 2'h3, {io_oe[1], io_o[1]})
    wr16(dds_pkg::MSC_ADDR, 16'h00C1);
    `CHK("drdy off", 1'b0, io_oe[1])
    wr16(dds_pkg::SMPL_ADDR, 16'h0000);
    wr16(dds_pkg::MSC_ADDR, 16'h0006);
    last_run = 0;
    n_sb = 0;
    tk();
    cyc(4);
    `CHK("tick ignored", 0, n_sb)
    @(posedge sys_clk_i) pin_drv[3] <= 1'b1;
    cyc(8);
    `CHK("ext strobe", 1, n_sb)
    cyc(2600);
    `CHK("ext drdy", 100 * 25, last_run)
    @(posedge sys_clk_i) alm <= 1'b1;
    wr16(dds_pkg::ALM_ADDR, 16'h0007);
    `CHK("alarm over io", 3'h6, {io_oe[1], io_o[1], io_o[0]})
    wr16(dds_pkg::ALM_ADDR, 16'h0006);
    `CHK("drdy over alarm", 3'h2, {io_oe[1], io_oe[0], io_o[0]})
    host.cut(16'hB655);
    wf(16'hB601);
    `CHK("cut frame dropped", 8'h01, period)
    close_out();
  end
endmodule
